// ===== verification/qbs_ctrl_model.sv
// qbs_ctrl_model: behavioural controller driving the sram command port
// assumes the bench calls cmd once per slot and fills wd and wm first
`timescale 1ns/100ps
module qbs_ctrl_model (
  input wire logic clock_i,
  output logic read_sel_n_o,
  output logic write_sel_n_o,
  output logic [3:0] addr_o,
  output logic [qbs_pkg::DATA_W-1:0] wd_rise_o,
  output logic [qbs_pkg::DATA_W-1:0] wd_fall_o,
  output logic [1:0] mk_rise_n_o,
  output logic [1:0] mk_fall_n_o
);
  logic [qbs_pkg::DATA_W-1:0] wd [4]; // beats of the next write
  logic [1:0] wm [4]; // byte masks per beat, bit 0 lower
  logic [2:0] wph_reg = 3'h0; // write selects seen on recent edges
  initial begin
    {read_sel_n_o, write_sel_n_o, addr_o} = 6'h30;
    {wd_rise_o, wd_fall_o, mk_rise_n_o, mk_fall_n_o} = {36'h0, 4'hF};
  end
  // one command slot, changed just after a falling edge
  task automatic cmd(input logic r, input logic w, input logic [3:0] a);
    @(negedge clock_i);
    read_sel_n_o <= r;
    write_sel_n_o <= w;
    addr_o <= a;
  endtask
  always @(posedge clock_i) wph_reg <= {wph_reg[1:0], !write_sel_n_o};
  // beats 0/1 before edge t+2, beats 2/3 before t+3, else toggling idle
  always @(negedge clock_i) begin
    if (wph_reg[2]) begin
      {wd_rise_o, wd_fall_o, mk_rise_n_o, mk_fall_n_o} <=
        {wd[2], wd[3], wm[2], wm[3]};
    end else if (wph_reg[1]) begin
      {wd_rise_o, wd_fall_o, mk_rise_n_o, mk_fall_n_o} <=
        {wd[0], wd[1], wm[0], wm[1]};
    end else begin
      {wd_rise_o, wd_fall_o} <= ~{wd_rise_o, wd_fall_o};
      {mk_rise_n_o, mk_fall_n_o} <= 4'hF;
    end
  end
endmodule

// ===== verification/qbs_sram_properties.sv
// qbs_sram_properties: port-level checks of read timing and idle output
// assumes binding to qbs_sram; watches its ports only
`timescale 1ns/100ps
module qbs_sram_properties (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic read_sel_n_i,
  input wire logic write_sel_n_i,
  input wire logic [qbs_pkg::DATA_W-1:0] rdata_rise_o,
  input wire logic [qbs_pkg::DATA_W-1:0] rdata_fall_o,
  input wire logic rdata_oe_n_o,
  input wire logic rd_beat_first_o
);
  logic [3:0] rd_hist_reg; // reads taken on recent edges, newest bit 0
  logic rd_take; // read accepted at this edge
  assign rd_take = !read_sel_n_i && !rd_hist_reg[0];
  ////////////////////////////////////////////////////////////////////////
  // history of accepted reads
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      rd_hist_reg <= 4'h0;
    end else begin
      rd_hist_reg <= {rd_hist_reg[2:0], rd_take};
    end
  end
  default clocking @(posedge clock_i); endclocking
  default disable iff (!resetn_i);
  ////////////////////////////////////////////////////////////////////////
  a_read_latency:
  assert property (rd_take |-> ##3 (!rdata_oe_n_o && rd_beat_first_o)
    ##1 (!rdata_oe_n_o && !rd_beat_first_o)) else $error("late burst");
  a_oe_window:
  assert property (rdata_oe_n_o == !(rd_hist_reg[2] || rd_hist_reg[3]))
    else $error("output enable outside burst");
  a_first_beat:
  assert property (rd_beat_first_o == rd_hist_reg[2]) else $error("beat");
  a_read_discard:
  assert property (rd_take ##1 !read_sel_n_i |-> ##3 !rd_beat_first_o)
    else $error("second read not discarded");
  a_idle_hiz:
  assert property (read_sel_n_i [*4] |=> rdata_oe_n_o) else $error("hiz");
  a_burst_pair:
  assert property (rd_beat_first_o |=> !rdata_oe_n_o && !rd_beat_first_o)
    else $error("burst not four words");
  a_out_hold:
  assert property (rdata_oe_n_o && $past(rdata_oe_n_o) |->
    $stable(rdata_rise_o) && $stable(rdata_fall_o)) else $error("hold");
  a_reset_quiet:
  assert property (disable iff (1'b0) !resetn_i |=> rdata_oe_n_o &&
    !rd_beat_first_o && rdata_rise_o == '0) else $error("reset state");
  c_read: cover property (rd_take);
  c_discard: cover property (rd_take ##1 !read_sel_n_i);
  c_collide: cover property (!read_sel_n_i && !write_sel_n_i);
endmodule
bind qbs_sram qbs_sram_properties qbs_sram_properties_i (
  .clock_i(clock_i), .resetn_i(resetn_i), .read_sel_n_i(read_sel_n_i),
  .write_sel_n_i(write_sel_n_i), .rdata_rise_o(rdata_rise_o),
  .rdata_fall_o(rdata_fall_o), .rdata_oe_n_o(rdata_oe_n_o),
  .rd_beat_first_o(rd_beat_first_o));

// ===== verification/test_quad_port_burst4_sram_cmd_timing.sv
// test_quad_port_burst4_sram_cmd_timing: self-checking sram bench
// assumes qbs_sram, its checker and the controller model compiled first
`timescale 1ns/100ps
module test_quad_port_burst4_sram_cmd_timing;
  typedef struct packed {logic [3:0] a; logic [17:0] d; logic [7:0] m;}
    qbs_row_t;
  qbs_row_t rows [4] = '{'{4'h0, 18'h25A5A, 8'h00},
    '{4'h4, 18'h1C3C3, 8'hE4}, '{4'hE, 18'h30FF0, 8'h1B},
    '{4'h2, 18'h01234, 8'hFF}};
  logic clock_i = 1'b0;
  logic resetn_i = 1'b0;
  logic rs_n, ws_n, oe_n, first;
  logic [3:0] addr;
  logic [17:0] wd_r, wd_f, rd_r, rd_f, exp_mem [16];
  logic [1:0] mk_r, mk_f;
  int fails = 0;
  int n_compared = 0;
  int cycles = 0;
  qbs_ctrl_model qbs_ctrl_model_i (.clock_i(clock_i), .read_sel_n_o(rs_n),
    .write_sel_n_o(ws_n), .addr_o(addr), .wd_rise_o(wd_r),
    .wd_fall_o(wd_f), .mk_rise_n_o(mk_r), .mk_fall_n_o(mk_f));
  qbs_sram qbs_sram_i (.clock_i(clock_i), .resetn_i(resetn_i),
    .read_sel_n_i(rs_n), .write_sel_n_i(ws_n), .addr_i(addr),
    .wdata_rise_i(wd_r), .wdata_fall_i(wd_f),
    .lower_byte_write_mask_n_rise_i(mk_r[0]),
    .upper_byte_write_mask_n_rise_i(mk_r[1]),
    .lower_byte_write_mask_n_fall_i(mk_f[0]),
    .upper_byte_write_mask_n_fall_i(mk_f[1]), .rdata_rise_o(rd_r),
    .rdata_fall_o(rd_f), .rdata_oe_n_o(oe_n), .rd_beat_first_o(first));
  initial forever #25 clock_i = ~clock_i;
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 2000) begin
      fails++;
      conclude;
    end
  end
  task automatic conclude;
    if (fails == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [17:0] seen, input logic [17:0] want);
    n_compared++;
    if (seen !== want) begin
      fails++;
      $display("[FAIL] %0t seen %h want %h", $time, seen, want);
    end
  endtask
  task automatic go(input logic r, input logic w, input logic [3:0] a);
    qbs_ctrl_model_i.cmd(r, w, a);
  endtask
  task automatic idle(input int n);
    repeat (n) go(1'b1, 1'b1, 4'h0);
  endtask
  task automatic load(input logic [17:0] d, input logic [7:0] m);
    for (int i = 0; i < 4; i++) begin
      qbs_ctrl_model_i.wd[i] = d ^ {9{i[1:0]}};
      qbs_ctrl_model_i.wm[i] = m[2*i+:2];
    end
  endtask
  // expected memory after a masked four-beat write
  task automatic upd(input logic [3:0] a, input logic [17:0] d,
    input logic [7:0] m);
    logic [3:0] j;
    logic [17:0] w;
    for (int i = 0; i < 4; i++) begin
      j = a + 4'(i);
      w = d ^ {9{i[1:0]}};
      if (!m[2*i]) exp_mem[j][8:0] = w[8:0];
      if (!m[2*i+1]) exp_mem[j][17:9] = w[17:9];
    end
  endtask
  task automatic beats(input logic [3:0] a);
    idle(1);
    chk(first, 1'b1);
    chk(rd_r, exp_mem[a]);
    chk(rd_f, exp_mem[a + 4'h1]);
    idle(1);
    chk(oe_n, 1'b0);
    chk(rd_r, exp_mem[a + 4'h2]);
    chk(rd_f, exp_mem[a + 4'h3]);
  endtask
  task automatic rd_chk(input logic [3:0] a);
    go(1'b0, 1'b1, a);
    idle(2);
    beats(a);
  endtask
  initial begin
    for (int i = 0; i < 16; i++) exp_mem[i] = '0;
    repeat (20) @(negedge clock_i);
    resetn_i = 1'b1;
    chk(oe_n, 1'b1);
    chk(rd_r, 18'h0);
    foreach (rows[k]) begin
      load(rows[k].d, rows[k].m);
      go(1'b1, 1'b0, rows[k].a);
      idle(4);
      upd(rows[k].a, rows[k].d, rows[k].m);
      rd_chk(rows[k].a);
    end
    // read at t, write to the same base at t+1
    load(18'h3AAAA, 8'h00);
    go(1'b0, 1'b1, 4'h8);
    go(1'b1, 1'b0, 4'h8);
    idle(1);
    beats(4'h8);
    idle(2);
    upd(4'h8, 18'h3AAAA, 8'h00);
    rd_chk(4'h8);
    // read and write together after idle: write dropped
    load(18'h15555, 8'h00);
    go(1'b0, 1'b0, 4'h8);
    idle(2);
    beats(4'h8);
    idle(2);
    rd_chk(4'h8);
    // back-to-back reads, then back-to-back writes
    go(1'b0, 1'b1, 4'h0);
    go(1'b0, 1'b1, 4'h4);
    idle(1);
    beats(4'h0);
    idle(1);
    chk(oe_n, 1'b1);
    load(18'h2D2D2, 8'h00);
    go(1'b1, 1'b0, 4'h0);
    go(1'b1, 1'b0, 4'h8);
    idle(4);
    upd(4'h0, 18'h2D2D2, 8'h00);
    rd_chk(4'h8);
    rd_chk(4'h0);
    // same-type commands two edges apart: both bursts run in full
    load(18'h0F0F0, 8'h00);
    go(1'b1, 1'b0, 4'h4);
    idle(1);
    go(1'b1, 1'b0, 4'hC);
    idle(4);
    upd(4'h4, 18'h0F0F0, 8'h00);
    upd(4'hC, 18'h0F0F0, 8'h00);
    go(1'b0, 1'b1, 4'h4);
    idle(1);
    go(1'b0, 1'b1, 4'hC);
    beats(4'h4);
    beats(4'hC);
    conclude;
  end
endmodule

// ===== verilog/qbs_if.sv
// qbs_if: carries one write beat pair from the port logic to storage
// assumes both ends run on the same clock
`timescale 1ns/100ps
interface qbs_if #(
  parameter int unsigned AW = 4
);
  logic we_a;                                // even beat write enable
  logic [AW-1:0] addr_a;                     // even beat address
  logic [qbs_pkg::DATA_W-1:0] data_a;        // even beat data
  logic [1:0] keep_a_n;                      // even beat byte masks, low writes
  logic we_b;                                // odd beat write enable
  logic [AW-1:0] addr_b;                     // odd beat address
  logic [qbs_pkg::DATA_W-1:0] data_b;        // odd beat data
  logic [1:0] keep_b_n;                      // odd beat byte masks
  logic [AW-1:0] raddr;                      // read base address of pair
  logic [qbs_pkg::DATA_W-1:0] rdata_a;       // word at raddr
  logic [qbs_pkg::DATA_W-1:0] rdata_b;       // word at raddr+1
  modport ctrl (output we_a, addr_a, data_a, keep_a_n, we_b, addr_b,
    data_b, keep_b_n, raddr, input rdata_a, rdata_b);
  modport mem (input we_a, addr_a, data_a, keep_a_n, we_b, addr_b,
    data_b, keep_b_n, raddr, output rdata_a, rdata_b);
endinterface

// ===== verilog/qbs_pkg.sv
// qbs_pkg: shared constants for the burst-of-four sram core model
// assumes a single 20 MHz clock; half-cycle beats are carried as pairs
package qbs_pkg;
  localparam int unsigned DATA_W = 18;  // x18 word width
  localparam int unsigned ADDR_W = 4;   // default address width, small
  localparam int unsigned BURST_LEN = 4;  // fixed four-beat burst
  localparam int unsigned LO_LSB = 0;   // lower byte field start
  localparam int unsigned LO_W = 9;     // lower byte field width
  localparam int unsigned HI_LSB = 9;   // upper byte field start
  localparam int unsigned HI_W = 9;     // upper byte field width
  localparam int unsigned RD_LAT = 2;   // cycles from command to first beat
  localparam int unsigned WR_LAT = 2;   // cycles from command to first capture
  // burst slot state, gray along idle -> armed -> first half -> second half
  typedef enum logic [1:0] {
    QBS_IDLE = 2'h0,
    QBS_ARM = 2'h1,
    QBS_BEAT01 = 2'h3,
    QBS_BEAT23 = 2'h2
  } qbs_phase_t;
endpackage

// ===== verilog/qbs_sram.sv
// qbs_sram: command, burst and byte-mask timing of a burst-of-four
// separate-port ddr sram, modelled at full-cycle rate
// assumes commands are sampled on each clock_i rising edge (true phase);
// the inverted-phase beats arrive as a second lane in the same cycle;
// the controller keeps same-type commands two edges apart and stops
// the clock only once every burst has finished
// the storage array is a separate module reached through qbs_if
//
// Summary of operation
// - read beats out two cycles after command
// - write beats captured two cycles after command
// - every burst is four words; a read taken on the last beat edge keeps beats 2/3 driven one extra cycle
// - stopped clock holds data states unchanged
// - back-to-back same-type command is discarded
// - read and write after idle: read only
// - low mask enables its byte lane
// - both masks high: beat leaves memory unchanged
// - burst addresses run base, +1, +2, +3
`timescale 1ns/100ps
module qbs_sram #(
  parameter int unsigned AW = qbs_pkg::ADDR_W
) (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic read_sel_n_i,               // read select, active low
  input wire logic write_sel_n_i,              // write select, active low
  input wire logic [AW-1:0] addr_i,            // burst base address
  input wire logic [qbs_pkg::DATA_W-1:0] wdata_rise_i, // true-edge beat
  input wire logic [qbs_pkg::DATA_W-1:0] wdata_fall_i, // inverted-edge beat
  input wire logic lower_byte_write_mask_n_rise_i,
  input wire logic upper_byte_write_mask_n_rise_i,
  input wire logic lower_byte_write_mask_n_fall_i,
  input wire logic upper_byte_write_mask_n_fall_i,
  output logic [qbs_pkg::DATA_W-1:0] rdata_rise_o, // beat 0 / 2
  output logic [qbs_pkg::DATA_W-1:0] rdata_fall_o, // beat 1 / 3
  output logic rdata_oe_n_o,                   // low while read data driven
  output logic rd_beat_first_o                 // high on beats 0/1
);
  typedef struct packed {
    qbs_pkg::qbs_phase_t rd_ph;       // read pipeline phase
    qbs_pkg::qbs_phase_t wr_ph;       // write pipeline phase
    logic [AW-1:0] rd_addr;           // registered read base
    logic [AW-1:0] wr_addr;           // registered write base
    // a command taken while the previous burst still runs waits here,
    // so the running burst keeps its own base until its last beat
    logic [AW-1:0] rd_base;           // base of the next read burst
    logic [AW-1:0] wr_base;           // base of the next write burst
    logic rd_prev;                    // read accepted last edge
    logic wr_prev;                    // write accepted last edge
    logic [qbs_pkg::DATA_W-1:0] rd_a; // driven rise beat
    logic [qbs_pkg::DATA_W-1:0] rd_b; // driven fall beat
    logic oe_n;                       // output enable, low drives
    logic first;                      // first half of read burst
  } qbs_sram_t;
  qbs_sram_t state_reg;  // all control state
  qbs_sram_t state_next; // next control state

  qbs_if #(.AW(AW)) mem_port (); // storage link
  logic rd_go; // read accepted this edge
  logic wr_go; // write accepted this edge

  // add a small offset to a burst base, wrapping in the address width
  function automatic logic [AW-1:0] qbs_offs(input logic [AW-1:0] base,
    input logic [1:0] k);
    return AW'(base + AW'(k));
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // command acceptance; the previous-edge flags give the two-edge spacing
  // of same-type commands and the idle test for a colliding pair
  always_comb begin
    rd_go = !read_sel_n_i && !state_reg.rd_prev;
    // write ignored if same-type repeat, or colliding read after idle
    wr_go = !write_sel_n_i && !state_reg.wr_prev
      && !(rd_go && !state_reg.rd_prev && !state_reg.wr_prev);
  end

  //////////////////////////////////////////////////////////////////////////
  // next state: read and write pipelines run independently
  // each pipeline holds one running burst and at most one waiting burst
  always_comb begin
    state_next = state_reg;
    state_next.rd_prev = rd_go;
    state_next.wr_prev = wr_go;
    // storage port defaults: no write, addresses at the running base
    mem_port.we_a = 1'b0;
    mem_port.we_b = 1'b0;
    mem_port.addr_a = state_reg.wr_addr;
    mem_port.addr_b = state_reg.wr_addr;
    mem_port.data_a = wdata_rise_i;
    mem_port.data_b = wdata_fall_i;
    mem_port.keep_a_n = {upper_byte_write_mask_n_rise_i,
      lower_byte_write_mask_n_rise_i};
    mem_port.keep_b_n = {upper_byte_write_mask_n_fall_i,
      lower_byte_write_mask_n_fall_i};
    // read pipeline: arm at t+1, beats 0/1 at t+2, beats 2/3 at t+3;
    // the read address of the storage pair is decoded outside this
    // process so that the lookup does not loop back into it
    case (state_reg.rd_ph)
      // armed: the waiting base becomes the running base
      qbs_pkg::QBS_ARM: begin
        state_next.rd_addr = state_reg.rd_base;
        state_next.rd_ph = qbs_pkg::QBS_BEAT01;
      end
      // first half: words base and base+1 go out
      qbs_pkg::QBS_BEAT01: begin
        state_next.rd_a = mem_port.rdata_a;
        state_next.rd_b = mem_port.rdata_b;
        state_next.oe_n = 1'b0;
        state_next.first = 1'b1;
        state_next.rd_ph = qbs_pkg::QBS_BEAT23;
      end
      // second half: words base+2 and base+3 go out
      qbs_pkg::QBS_BEAT23: begin
        state_next.rd_a = mem_port.rdata_a;
        state_next.rd_b = mem_port.rdata_b;
        state_next.oe_n = 1'b0;
        state_next.first = 1'b0;
        state_next.rd_ph = qbs_pkg::QBS_IDLE;
        // a read taken on the last edge follows with no gap
        if (state_reg.rd_prev) begin
          state_next.rd_addr = state_reg.rd_base;
          state_next.rd_ph = qbs_pkg::QBS_BEAT01;
        end
      end
      // idle: outputs released, data left as it was
      default: begin
        state_next.oe_n = 1'b1;
        state_next.first = 1'b0;
        state_next.rd_ph = qbs_pkg::QBS_IDLE;
      end
    endcase
    // a new read parks its base; in the first half of a running burst
    // it leaves the phase alone, and the second half chains onto it
    if (rd_go) begin
      state_next.rd_base = addr_i;
      if (state_reg.rd_ph != qbs_pkg::QBS_BEAT01) begin
        state_next.rd_ph = qbs_pkg::QBS_ARM;
      end
    end
    // write pipeline: beats captured at t+2 and t+3
    case (state_reg.wr_ph)
      // armed: the waiting base becomes the running base
      qbs_pkg::QBS_ARM: begin
        state_next.wr_addr = state_reg.wr_base;
        state_next.wr_ph = qbs_pkg::QBS_BEAT01;
      end
      // first half: beats 0/1 land at base and base+1
      qbs_pkg::QBS_BEAT01: begin
        mem_port.we_a = 1'b1;
        mem_port.we_b = 1'b1;
        mem_port.addr_a = state_reg.wr_addr;
        mem_port.addr_b = qbs_offs(state_reg.wr_addr, 2'h1);
        state_next.wr_ph = qbs_pkg::QBS_BEAT23;
      end
      // second half: beats 2/3 land at base+2 and base+3
      qbs_pkg::QBS_BEAT23: begin
        mem_port.we_a = 1'b1;
        mem_port.we_b = 1'b1;
        mem_port.addr_a = qbs_offs(state_reg.wr_addr, 2'h2);
        mem_port.addr_b = qbs_offs(state_reg.wr_addr, 2'h3);
        state_next.wr_ph = qbs_pkg::QBS_IDLE;
        // a write taken on the last edge follows with no gap
        if (state_reg.wr_prev) begin
          state_next.wr_addr = state_reg.wr_base;
          state_next.wr_ph = qbs_pkg::QBS_BEAT01;
        end
      end
      // idle: nothing is written
      default: begin
        state_next.wr_ph = qbs_pkg::QBS_IDLE;
      end
    endcase
    // a new write parks its base the same way as a read does
    if (wr_go) begin
      state_next.wr_base = addr_i;
      if (state_reg.wr_ph != qbs_pkg::QBS_BEAT01) begin
        state_next.wr_ph = qbs_pkg::QBS_ARM;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // state register; with no clock edges everything holds
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      state_reg.rd_ph <= qbs_pkg::QBS_IDLE;
      state_reg.wr_ph <= qbs_pkg::QBS_IDLE;
      state_reg.rd_addr <= '0;
      state_reg.wr_addr <= '0;
      state_reg.rd_base <= '0;
      state_reg.wr_base <= '0;
      state_reg.rd_prev <= 1'b0;
      state_reg.wr_prev <= 1'b0;
      state_reg.rd_a <= '0;
      state_reg.rd_b <= '0;
      state_reg.oe_n <= 1'b1;
      state_reg.first <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  // read pair address: base in the first half, base+2 in the second;
  // kept out of the next-state process, which reads the looked-up pair
  assign mem_port.raddr = (state_reg.rd_ph == qbs_pkg::QBS_BEAT23) ?
    qbs_offs(state_reg.rd_addr, 2'h2) : state_reg.rd_addr;

  // storage array
  qbs_store #(.AW(AW)) u_store (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .port(mem_port.mem)
  );

  // outputs straight from flip-flops
  // read data keeps its last value while the outputs are released
  assign rdata_rise_o = state_reg.rd_a;
  assign rdata_fall_o = state_reg.rd_b;
  assign rdata_oe_n_o = state_reg.oe_n;
  assign rd_beat_first_o = state_reg.first;
endmodule

// ===== verilog/qbs_store.sv
// qbs_store: flip-flop array with per-byte masked two-beat write
// assumes the controller never writes one address twice in a cycle
`timescale 1ns/100ps
module qbs_store #(
  parameter int unsigned AW = 4
) (
  input wire logic clock_i,
  input wire logic resetn_i,
  qbs_if.mem port
);
  localparam int unsigned DEPTH = 1 << AW;
  typedef struct packed {
    logic [DEPTH-1:0][qbs_pkg::DATA_W-1:0] mem;
  } qbs_store_t;
  qbs_store_t state_reg;  // memory contents
  qbs_store_t state_next; // next contents

  // merge one beat into a word under its byte masks
  function automatic logic [qbs_pkg::DATA_W-1:0] qbs_merge(
    input logic [qbs_pkg::DATA_W-1:0] old_w,
    input logic [qbs_pkg::DATA_W-1:0] new_w,
    input logic [1:0] keep_n);
    logic [qbs_pkg::DATA_W-1:0] r;
    r = old_w;
    if (!keep_n[0]) begin
      r[qbs_pkg::LO_LSB +: qbs_pkg::LO_W] =
        new_w[qbs_pkg::LO_LSB +: qbs_pkg::LO_W];
    end
    if (!keep_n[1]) begin
      r[qbs_pkg::HI_LSB +: qbs_pkg::HI_W] =
        new_w[qbs_pkg::HI_LSB +: qbs_pkg::HI_W];
    end
    return r;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // next contents: both masks high leave the word untouched
  always_comb begin
    state_next = state_reg;
    if (port.we_a) begin
      state_next.mem[port.addr_a] = qbs_merge(state_reg.mem[port.addr_a],
        port.data_a, port.keep_a_n);
    end
    if (port.we_b) begin
      state_next.mem[port.addr_b] = qbs_merge(state_next.mem[port.addr_b],
        port.data_b, port.keep_b_n);
    end
  end

  // register contents, cleared by reset
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // read pair, combinational lookup
  assign port.rdata_a = state_reg.mem[port.raddr];
  assign port.rdata_b = state_reg.mem[AW'(port.raddr + AW'(1))];
endmodule
